// ==== rtl/wsr_bank.sv ====
// How it works
// (RULE1) bits 15:13 of each frame pick the register and bit 12 picks read/write or read-only access.
// (RULE2) the addressed register's status shifts out on the data output while new data shifts in.
// (RULE3) a read-only frame returns the register and leaves every stored field except the access status bit unchanged.
// (RULE4) the access status bit shows 0 after read/write and 1 after read-only access, resetting to 0.
// (RULE5) the mode select bit gives window/timeout when 0 and timeout/off when 1 in normal/standby, reset 0.
// (RULE6) the period field maps codes 0 to 7 onto 8 to 4096 ms and returns to code 100 after any reset.
// (RULE7) with the disable pin low the off flag reads 0 and the watchdog mode follows the mode select bit.
// (RULE8) with the disable pin high the watchdog is off, the off flag reads 1 and a software reset is issued.
// (RULE9) the regulator flag reads 1 while the regulator is low and 0 once it has recovered.
// (RULE10) the first wake flag is read-only and follows the first wake input level.
// (RULE11) the second wake flag is read-only and follows the second wake input level.
// (RULE12) reserved bits always read their fixed values and writes to them are dropped.
// (RULE13) the address bits of a word are read-only and always return that word's own code.
`timescale 1ns/1ns
module wsr_bank
  import wsr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_sel_n,
  input wire logic link_sck,
  input wire logic link_sdi,
  output logic link_sdo_o,
  output logic link_sdo_oe,
  input wire logic watchdog_disable_pin,
  input wire logic main_regulator_low,
  input wire logic first_wake_input,
  input wire logic second_wake_input,
  input wire logic op_normal,
  output wsr_wd_mode_e wd_mode,
  output logic [2:0] watchdog_period_select,
  output logic [12:0] wd_period_ms,
  output logic soft_reset
);

  logic [WSR_SYNC_W-1:0] pins_s;
  logic sel_n_s;
  logic sck_s;
  logic sdi_s;
  logic sck_q_ff;
  logic sel_q_ff;
  logic dis_q_ff;
  wsr_status_s st;
  wsr_link_e link_ff;
  logic [4:0] cnt_ff;
  logic [15:0] rx_ff;
  logic [2:0] addr_ff;
  logic readonly_access_bit_ff;
  logic mode_acc_ff;
  wsr_wd_cfg_s cfg_ff;
  logic sdo_ff;
  logic sdo_oe_ff;
  wsr_wd_mode_e mode_ff;
  logic [12:0] period_ms_ff;
  logic soft_rst_ff;
  logic sck_fall;
  logic sck_rise;
  logic frame_start;
  logic frame_end;
  logic frame_ok;
  logic dis_rise;
  logic [15:0] resp;
  wsr_wd_mode_e nxt_mode;

  wsr_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({second_wake_input, first_wake_input, main_regulator_low, watchdog_disable_pin,
               link_sdi, link_sck, link_sel_n}),
    .sync_out(pins_s)
  );

  assign sel_n_s = pins_s[WSR_S_SEL];
  assign sck_s = pins_s[WSR_S_SCK];
  assign sdi_s = pins_s[WSR_S_SDI];
  assign st.dis = pins_s[WSR_S_DIS];
  assign st.reg_low = pins_s[WSR_S_REGLOW]; // RULE9
  assign st.wake_a = pins_s[WSR_S_WAKEA]; // RULE10
  assign st.wake_b = pins_s[WSR_S_WAKEB]; // RULE11

  assign sck_fall = sck_q_ff & ~sck_s;
  assign sck_rise = ~sck_q_ff & sck_s;
  assign frame_start = sel_q_ff & ~sel_n_s;
  assign frame_end = ~sel_q_ff & sel_n_s;
  assign frame_ok = frame_end && (link_ff == WSR_SHIFT) && (cnt_ff == WSR_FRAME_LEN);
  assign dis_rise = st.dis & ~dis_q_ff;
  assign resp = wsr_resp(addr_ff, readonly_access_bit_ff, mode_acc_ff, cfg_ff, st); // RULE12 RULE13

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sck_q_ff <= 1'b0;
      sel_q_ff <= 1'b1;
      dis_q_ff <= 1'b0;
    end
    else
    begin
      sck_q_ff <= sck_s;
      sel_q_ff <= sel_n_s;
      dis_q_ff <= st.dis;
    end
  end

  // frame state and receive shifter
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      link_ff <= WSR_IDLE;
      cnt_ff <= 5'h00;
      rx_ff <= 16'h0000;
      addr_ff <= 3'h0;
    end
    else
    begin
      case (link_ff)
        WSR_IDLE:
        begin
          if (frame_start)
          begin
            link_ff <= WSR_SHIFT;
            cnt_ff <= 5'h00;
          end
        end
        WSR_SHIFT:
        begin
          if (sel_n_s)
            link_ff <= WSR_IDLE;
          else if (sck_fall)
          begin
            rx_ff <= {rx_ff[14:0], sdi_s};
            if (cnt_ff != 5'h1F)
              cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == WSR_MIRROR_CNT)
              addr_ff <= {rx_ff[1:0], sdi_s}; // RULE1
          end
        end
        default: link_ff <= WSR_IDLE;
      endcase
    end
  end

  // data output, shifted on rising clock edges
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end
    else
    begin
      sdo_oe_ff <= ~sel_n_s;
      if (frame_start)
        sdo_ff <= 1'b0;
      else if (link_ff == WSR_SHIFT && cnt_ff == WSR_MIRROR_CNT)
        sdo_ff <= sdi_s; // RULE13
      else if (link_ff == WSR_SHIFT && sck_rise && cnt_ff > WSR_MIRROR_CNT && cnt_ff < WSR_FRAME_LEN)
        sdo_ff <= resp[4'(15 - cnt_ff)]; // RULE2
    end
  end

  // stored fields, software reset wins over a frame in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_ff <= WSR_CFG_RST;
      readonly_access_bit_ff <= WSR_ACC_RST;
      mode_acc_ff <= WSR_ACC_RST;
    end
    else if (dis_rise)
    begin
      cfg_ff <= WSR_CFG_RST; // RULE6
      readonly_access_bit_ff <= WSR_ACC_RST;
      mode_acc_ff <= WSR_ACC_RST;
    end
    else if (frame_ok)
    begin
      if (rx_ff[WSR_ADDR_MSB:WSR_ADDR_LSB] == WSR_ADDR_WDS)
      begin
        readonly_access_bit_ff <= rx_ff[WSR_ACC_POS]; // RULE4
        if (!rx_ff[WSR_ACC_POS])
          cfg_ff <= rx_ff[WSR_MSEL_POS:WSR_PER_LSB]; // RULE3
      end
      else if (rx_ff[WSR_ADDR_MSB:WSR_ADDR_LSB] == WSR_ADDR_MODE)
        mode_acc_ff <= rx_ff[WSR_ACC_POS]; // RULE4
    end
  end

  always_comb
  begin
    if (st.dis)
      nxt_mode = WSR_WD_OFF; // RULE8
    else if (op_normal)
      nxt_mode = cfg_ff.mode_sel ? WSR_WD_TIMEOUT : WSR_WD_WINDOW; // RULE5 RULE7
    else
      nxt_mode = cfg_ff.mode_sel ? WSR_WD_OFF : WSR_WD_TIMEOUT; // RULE5 RULE7
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_ff <= WSR_WD_WINDOW;
      period_ms_ff <= WSR_PER_MS_RST;
      soft_rst_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      period_ms_ff <= wsr_period_ms(cfg_ff.period_sel); // RULE6
      soft_rst_ff <= dis_rise; // RULE8
    end
  end

  assign link_sdo_o = sdo_ff;
  assign link_sdo_oe = sdo_oe_ff;
  assign wd_mode = mode_ff;
  assign watchdog_period_select = cfg_ff.period_sel;
  assign wd_period_ms = period_ms_ff;
  assign soft_reset = soft_rst_ff;

  // rx_ff holds still once the frame has ended, so it is read again after the commit
  a_readonly_keeps: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    (frame_ok && rx_ff[WSR_ACC_POS] && !dis_rise) |=> $stable(cfg_ff))
    else $error("read-only frame changed stored fields");
  a_access_status: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    (frame_ok && !dis_rise && rx_ff[15:13] == WSR_ADDR_WDS) |=> readonly_access_bit_ff == rx_ff[WSR_ACC_POS])
    else $error("access status does not match last access");
  a_write_takes: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    (frame_ok && !dis_rise && rx_ff[15:12] == 4'h0) |=> cfg_ff == rx_ff[WSR_MSEL_POS:WSR_PER_LSB])
    else $error("write to watchdog word not stored");
  a_mode_map: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    (!st.dis && op_normal && !cfg_ff.mode_sel) |=> mode_ff == WSR_WD_WINDOW)
    else $error("normal mode with select 0 is not windowed");
  a_off_mode: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    st.dis |=> mode_ff == WSR_WD_OFF)
    else $error("watchdog not off with disable pin high");
  a_soft_pulse: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    dis_rise |=> soft_reset ##1 !soft_reset)
    else $error("software reset not a single pulse");
  a_period_default: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
    dis_rise |=> watchdog_period_select == WSR_PER_RST ##1 wd_period_ms == WSR_PER_MS_RST)
    else $error("period not restored after software reset");
  a_off_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    (addr_ff == WSR_ADDR_WDS) |-> resp[WSR_OFF_POS] == st.dis && resp[WSR_RSV5_POS] && resp[2:0] == WSR_RSV_LOW_VAL)
    else $error("off flag or reserved bits wrong");
  a_first_bits: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    frame_start |=> !link_sdo_o [*2])
    else $error("address bit 15 not zero at frame start");
  a_wake_levels: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
    (addr_ff == WSR_ADDR_WDS) |-> resp[WSR_WAKEA_POS] == st.wake_a && resp[WSR_WAKEB_POS] == st.wake_b
      && resp[WSR_REGLOW_POS] == st.reg_low)
    else $error("input level flags wrong");

  c_write: cover property (@(posedge ref_clk) frame_ok && !rx_ff[12]);
  c_readonly: cover property (@(posedge ref_clk) frame_ok && rx_ff[12]);
  c_disable: cover property (@(posedge ref_clk) dis_rise);
  c_mode_word: cover property (@(posedge ref_clk) frame_ok && rx_ff[15:13] == WSR_ADDR_MODE);

endmodule // wsr_bank

// ==== inc/wsr_pkg.sv ====
package wsr_pkg;

  // register address codes (bits 15:13 of a frame)
  localparam logic [2:0] WSR_ADDR_WDS = 3'h0;
  localparam logic [2:0] WSR_ADDR_MODE = 3'h1;

  // frame layout
  localparam int WSR_FRAME_BITS = 16;
  localparam logic [4:0] WSR_FRAME_LEN = 5'h10;
  localparam int WSR_ADDR_MSB = 15;
  localparam int WSR_ADDR_LSB = 13;
  localparam int WSR_ACC_POS = 12;
  localparam int WSR_MSEL_POS = 11;
  localparam int WSR_PER_MSB = 10;
  localparam int WSR_PER_LSB = 8;
  localparam int WSR_OFF_POS = 7;
  localparam int WSR_REGLOW_POS = 6;
  localparam int WSR_RSV5_POS = 5;
  localparam int WSR_WAKEA_POS = 4;
  localparam int WSR_WAKEB_POS = 3;
  // bit of the outgoing frame that mirrors the incoming address bit
  localparam logic [4:0] WSR_MIRROR_CNT = 5'h02;

  // reset and fixed values
  localparam logic WSR_ACC_RST = 1'b0;
  localparam logic WSR_MSEL_RST = 1'b0;
  localparam logic [2:0] WSR_PER_RST = 3'h4;
  localparam logic [12:0] WSR_PER_MS_RST = 13'h0080;
  localparam logic WSR_RSV5_VAL = 1'b1;
  localparam logic [2:0] WSR_RSV_LOW_VAL = 3'h0;

  // synchroniser bank layout
  localparam int WSR_SYNC_W = 7;
  localparam logic [WSR_SYNC_W-1:0] WSR_SYNC_RST = 7'h01;
  localparam int WSR_S_SEL = 0;
  localparam int WSR_S_SCK = 1;
  localparam int WSR_S_SDI = 2;
  localparam int WSR_S_DIS = 3;
  localparam int WSR_S_REGLOW = 4;
  localparam int WSR_S_WAKEA = 5;
  localparam int WSR_S_WAKEB = 6;

  typedef enum logic [1:0] {WSR_WD_OFF, WSR_WD_WINDOW, WSR_WD_TIMEOUT} wsr_wd_mode_e;
  typedef enum logic {WSR_IDLE, WSR_SHIFT} wsr_link_e;

  typedef struct packed {
    logic mode_sel;
    logic [2:0] period_sel;
  } wsr_wd_cfg_s;

  typedef struct packed {
    logic dis;
    logic reg_low;
    logic wake_a;
    logic wake_b;
  } wsr_status_s;

  localparam wsr_wd_cfg_s WSR_CFG_RST = '{mode_sel: WSR_MSEL_RST, period_sel: WSR_PER_RST};

  function automatic logic [12:0] wsr_period_ms(input logic [2:0] code);
    case (code)
      3'h0: wsr_period_ms = 13'h0008;
      3'h1: wsr_period_ms = 13'h0010;
      3'h2: wsr_period_ms = 13'h0020;
      3'h3: wsr_period_ms = 13'h0040;
      3'h4: wsr_period_ms = 13'h0080;
      3'h5: wsr_period_ms = 13'h0100;
      3'h6: wsr_period_ms = 13'h0400;
      default: wsr_period_ms = 13'h1000;
    endcase
  endfunction

  function automatic logic [15:0] wsr_resp(input logic [2:0] addr, input logic acc_wds, input logic acc_mode,
                                           input wsr_wd_cfg_s cfg, input wsr_status_s st);
    logic [15:0] w;
    w = 16'h0000;
    w[WSR_ADDR_MSB:WSR_ADDR_LSB] = addr;
    if (addr == WSR_ADDR_WDS)
    begin
      w[WSR_ACC_POS] = acc_wds;
      w[WSR_MSEL_POS] = cfg.mode_sel;
      w[WSR_PER_MSB:WSR_PER_LSB] = cfg.period_sel;
      w[WSR_OFF_POS] = st.dis;
      w[WSR_REGLOW_POS] = st.reg_low;
      w[WSR_RSV5_POS] = WSR_RSV5_VAL;
      w[WSR_WAKEA_POS] = st.wake_a;
      w[WSR_WAKEB_POS] = st.wake_b;
      w[2:0] = WSR_RSV_LOW_VAL;
    end
    else if (addr == WSR_ADDR_MODE)
    begin
      w[WSR_ACC_POS] = acc_mode;
    end
    wsr_resp = w;
  endfunction

endpackage

// ==== rtl/wsr_sync.sv ====
`timescale 1ns/1ns
module wsr_sync
  import wsr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WSR_SYNC_W-1:0] async_in,
  output logic [WSR_SYNC_W-1:0] sync_out
);

  logic [WSR_SYNC_W-1:0] meta_ff;
  logic [WSR_SYNC_W-1:0] sync_ff;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= WSR_SYNC_RST;
      sync_ff <= WSR_SYNC_RST;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // wsr_sync

// ==== dv/wsr_spi_master.sv ====
`timescale 1ns/1ns
module wsr_spi_master
  import wsr_pkg::*;
(
  input wire logic ref_clk,
  output logic sel_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  initial
  begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask

  // msb first; fewer than 16 bits makes a short frame
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge ref_clk);
    sel_n <= 1'b0;
    half();
    for (int i = 0; i < nbits; i++)
    begin
      // shift on the rising edge, sample on the falling edge
      sdi <= tx[15-i];
      sck <= 1'b1;
      half();
      rx[15-i] = sdo;
      sck <= 1'b0;
      half();
    end
    sel_n <= 1'b1;
    // released data line shows the inverse
    sdi <= ~tx[16-nbits];
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // wsr_spi_master

// ==== dv/tb_watchdog_status_register_bank.sv ====
`timescale 1ns/1ns
module tb_watchdog_status_register_bank
  import wsr_pkg::*;
();
  logic ref_clk, rst, sel_n, sck, sdi, sdo_o, sdo_oe, dis_pin, reg_low, wake_a, wake_b, op_normal, soft_reset;
  wsr_wd_mode_e wd_mode;
  logic [2:0] period;
  logic [12:0] pms;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  wire sdo_w = sdo_oe ? sdo_o : 1'bz;

  wsr_spi_master u_m (.ref_clk(ref_clk), .sel_n(sel_n), .sck(sck), .sdi(sdi), .sdo(sdo_w));

  wsr_bank u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .link_sel_n(sel_n),
    .link_sck(sck),
    .link_sdi(sdi),
    .link_sdo_o(sdo_o),
    .link_sdo_oe(sdo_oe),
    .watchdog_disable_pin(dis_pin),
    .main_regulator_low(reg_low),
    .first_wake_input(wake_a),
    .second_wake_input(wake_b),
    .op_normal(op_normal),
    .wd_mode(wd_mode),
    .watchdog_period_select(period),
    .wd_period_ms(pms),
    .soft_reset(soft_reset)
  );

  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] resp0(input logic acc, input logic ms, input logic [2:0] code);
    return {3'h0, acc, ms, code, dis_pin, reg_low, 1'b1, wake_a, wake_b, 3'h0};
  endfunction

  task automatic t_reset();
    logic [15:0] rx;
    chk("period", 16'h0004, {13'h0, period});
    chk("ms", 16'h0080, {3'h0, pms});
    chk("sdo_oe", 16'h0000, {15'h0, sdo_oe});
    u_m.xfer(16'h1FFF, 16, rx);
    chk("resp_rst", resp0(1'b0, 1'b0, 3'h4), rx);
    u_m.xfer(16'h1000, 16, rx);
    chk("resp_ro", resp0(1'b1, 1'b0, 3'h4), rx);
  endtask

  task automatic t_period();
    logic [15:0] rx;
    logic [15:0] tab [8] = '{16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0400, 16'h1000};
    for (int c = 0; c < 8; c++)
    begin
      // read-only low byte (flags and reserved bits) written as ones
      u_m.xfer({5'h00, 3'(c), 8'hFF}, 16, rx);
      chk("period", 16'(c), {13'h0, period});
      chk("ms", tab[c], {3'h0, pms});
      chk("resp_wr", c == 0 ? resp0(1'b1, 1'b0, 3'h4) : resp0(1'b0, 1'b0, 3'(c - 1)), rx);
    end
  endtask

  task automatic t_mode();
    logic [15:0] rx;
    wsr_wd_mode_e tab [4] = '{WSR_WD_TIMEOUT, WSR_WD_WINDOW, WSR_WD_OFF, WSR_WD_TIMEOUT};
    for (int k = 0; k < 4; k++)
    begin
      op_normal <= k[0];
      u_m.xfer({4'h0, k[1], 11'h700}, 16, rx);
      chk("wd_mode", {14'h0, tab[k]}, {14'h0, wd_mode});
    end
  endtask

  task automatic t_status();
    logic [15:0] rx;
    for (int k = 0; k < 8; k++)
    begin
      {reg_low, wake_a, wake_b} <= 3'(k);
      repeat (5) @(posedge ref_clk);
      u_m.xfer(16'h1000, 16, rx);
      chk("status", resp0(k != 0, 1'b1, 3'h7), rx);
    end
  endtask

  task automatic t_other();
    logic [15:0] rx;
    u_m.xfer(16'h2000, 16, rx);
    chk("mode_word", 16'h2000, rx);
    u_m.xfer(16'h3000, 16, rx);
    chk("mode_rw", 16'h2000, rx);
    u_m.xfer(16'h2000, 16, rx);
    chk("mode_ro", 16'h3000, rx);
    u_m.xfer(16'h4FFF, 16, rx);
    u_m.xfer(16'h0000, 15, rx);
    u_m.xfer(16'h1000, 16, rx);
    chk("kept", resp0(1'b1, 1'b1, 3'h7), rx);
  endtask

  task automatic t_disable();
    logic [15:0] rx;
    int n;
    n = 0;
    @(posedge ref_clk);
    dis_pin <= 1'b1;
    repeat (12)
    begin
      @(negedge ref_clk);
      if (soft_reset === 1'b1)
        n++;
    end
    chk("pulses", 16'h0001, 16'(n));
    chk("wd_off", {14'h0, WSR_WD_OFF}, {14'h0, wd_mode});
    chk("period", 16'h0004, {13'h0, period});
    u_m.xfer(16'h1000, 16, rx);
    chk("resp_off", resp0(1'b0, 1'b0, 3'h4), rx);
    dis_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    u_m.xfer(16'h1000, 16, rx);
    chk("resp_on", resp0(1'b1, 1'b0, 3'h4), rx);
  endtask

  task automatic t_rerst();
    logic [15:0] rx;
    u_m.xfer(16'h0B00, 16, rx);
    chk("period_wr", 16'h0003, {13'h0, period});
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk("period_rerst", 16'h0004, {13'h0, period});
    chk("ms_rerst", 16'h0080, {3'h0, pms});
    u_m.xfer(16'h1000, 16, rx);
    chk("resp_rerst", resp0(1'b0, 1'b0, 3'h4), rx);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial
  begin
    forever
    begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 20000)
      begin
        bad_count++;
        end_sim();
      end
    end
  end

  initial
  begin
    rst = 1'b1;
    dis_pin = 1'b0;
    reg_low = 1'b0;
    wake_a = 1'b0;
    wake_b = 1'b0;
    op_normal = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    t_reset();
    t_period();
    t_mode();
    t_status();
    t_other();
    t_disable();
    t_rerst();
    end_sim();
  end
endmodule // tb_watchdog_status_register_bank
